//--- shared/otc_consts.svh
// constants of the offset trigger and configuration block
// ****************************************************************************
// Contract
// R1 - The pin acts as an offset trigger only when its function is set to offset input.
// R2 - The outside trigger source requests an equalization with a low-to-high edge on the pin.
// R3 - Each trigger makes the stored preset the present distance, later readings follow it.
// R4 - On equalization the thresholds move by the same amount as the distance correction.
// R5 - The sampling rate is chosen only from 100, 50, 20, 10, 5, 2 and 1 per second.
// R6 - A lower sampling rate gives finer resolution and a smaller least hysteresis.
// R7 - An emitter enable setting with on and off stops the light while off.
// R8 - With a disable pin, the emitter is off while that pin is active.
// R9 - When the disable pin serves the serial link, shutdown is by command, menu or the pin.
// R10 - A display selection chooses output states with distance or the analog value.
// R11 - In menu mode the device sends its own text menu unasked.
// R12 - Command mode is the default of three modes and acts on host commands.
// R13 - Continuous mode transmits repeatedly at a fixed interval unasked.
// R14 - The link runs at 9600, 38400 or 115200 baud, 38400 by default, same at host.
// R15 - The preset can be loaded from the present distance and cleared to zero.
// R16 - An offset reset command cancels equalization and restores the real distance.
// R17 - The pin is synchronised and each rising edge applies exactly one equalization.
// ****************************************************************************
`ifndef OTC_CONSTS_SVH
`define OTC_CONSTS_SVH
`define OTC_A_CTRL 4'h0
`define OTC_A_PRESET 4'h1
`define OTC_A_DIST_IN 4'h2
`define OTC_A_THR_IN 4'h3
`define OTC_A_CMD 4'h4
`define OTC_A_DIST 4'h5
`define OTC_A_THR 4'h6
`define OTC_A_STAT 4'h7
`define OTC_CLK_HZ 100000000
`define OTC_CTRL_RST 32'h0000_0221
`define OTC_B_PINFN 1:0
`define OTC_B_RATE 4:2
`define OTC_B_LASER 5
`define OTC_B_DISP 6
`define OTC_B_IFMODE 8:7
`define OTC_B_BAUD 10:9
`define OTC_B_INV 11
`define OTC_B_PINSER 12
`define OTC_B_SHUT 13
`define OTC_CMD_LOAD 0
`define OTC_CMD_CLR 1
`define OTC_CMD_RST 2
`define OTC_CMD_HOST 3
`define OTC_MENU_DIV 1000000
`define OTC_CONT_DIV 1000000
`define OTC_RESP_OKAY 2'h0
`define OTC_RESP_SLVERR 2'h2
`endif

//--- shared/otc_pkg.sv
// types of the offset trigger and configuration block
package otc_pkg;
  typedef enum logic [1:0] {otc_pin_none, otc_pin_offset, otc_pin_shutdown} otc_pinfn_e;
  typedef enum logic [1:0] {otc_if_comm, otc_if_menu, otc_if_cont} otc_ifmode_e;
  typedef enum logic [1:0] {otc_baud_9600, otc_baud_38400, otc_baud_115200} otc_baud_e;
  typedef enum {otc_idle, otc_wresp, otc_rresp} otc_bus_e;
endpackage

//--- rtl/otc_top.sv
// offset trigger, emitter and interface configuration with axi4-lite registers
`timescale 1ns/100ps
`include "otc_consts.svh"
module otc_top
  import otc_pkg::*;
#(
  parameter int DW = 32,
  parameter int MENU_DIV = `OTC_MENU_DIV,
  parameter int CONT_DIV = `OTC_CONT_DIV
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic multifunction_pin,
  input wire logic disable_pin,
  output logic emitter_on,
  output logic [2:0] sample_rate_sel,
  output logic display_selection,
  output logic [1:0] baud_sel,
  output logic menu_send,
  output logic cont_send,
  output logic host_cmd_enable,
  output logic [DW-1:0] reported_distance,
  output logic [DW-1:0] switch_threshold
);

  // ****************************************************************************
  // register index decode
  // ****************************************************************************
  function automatic logic [3:0] otc_index(input logic [31:0] addr);
    otc_index = addr[5:2];
  endfunction

  function automatic logic otc_mapped(input logic [31:0] addr);
    otc_mapped = (addr[31:6] == 26'h0) && (addr[5:2] <= `OTC_A_STAT);
  endfunction

  // ****************************************************************************
  // state
  // ****************************************************************************
  otc_bus_e bus_st, next_bus_st;
  logic [31:0] ctrl, next_ctrl;
  logic [DW-1:0] preset, next_preset;
  logic [DW-1:0] dist_in, next_dist_in;
  logic [DW-1:0] thr_in, next_thr_in;
  logic [DW-1:0] corr, next_corr;
  logic applied, next_applied;
  logic [15:0] trig_cnt, next_trig_cnt;
  logic [2:0] mf_sync, next_mf_sync;
  logic [1:0] dis_sync, next_dis_sync;
  logic host_cmd, next_host_cmd;
  logic [31:0] aw_hold, next_aw_hold;
  logic [31:0] w_hold, next_w_hold;
  logic [3:0] ws_hold, next_ws_hold;
  logic aw_got, next_aw_got;
  logic w_got, next_w_got;
  logic [31:0] rdata, next_rdata;
  logic [1:0] resp, next_resp;
  logic [31:0] menu_cnt, next_menu_cnt;
  logic [31:0] cont_cnt, next_cont_cnt;
  logic menu_p, next_menu_p;
  logic cont_p, next_cont_p;
  logic emit, next_emit;
  logic [DW-1:0] rep, next_rep;
  logic [DW-1:0] thr, next_thr;

  // derived strobes and bus signals, and fields viewed from the control word
  logic pin_level;
  logic mf_rise;
  logic do_write;
  logic [3:0] widx;
  logic [31:0] wmerged;
  otc_pinfn_e pinfn;
  otc_ifmode_e ifmode;

  assign pinfn = otc_pinfn_e'(ctrl[`OTC_B_PINFN]);
  assign ifmode = otc_ifmode_e'(ctrl[`OTC_B_IFMODE]);

  // ****************************************************************************
  // pin synchronisers and trigger edge
  // ****************************************************************************
  // mf_sync[0] is read only by mf_sync[1]; the edge looks at stages 1 and 2
  always_comb
  begin
    next_mf_sync = {mf_sync[1:0], multifunction_pin};
    next_dis_sync = {dis_sync[0], disable_pin};
  end

  // inversion applies before the edge so an inverted input triggers on its falling level change
  assign pin_level = mf_sync[1] ^ ctrl[`OTC_B_INV];
  assign mf_rise = pin_level & ~(mf_sync[2] ^ ctrl[`OTC_B_INV]) // R17
    & (pinfn == otc_pin_offset); // R1 R2

  // ****************************************************************************
  // axi4-lite write and read channels
  // ****************************************************************************
  assign widx = otc_index(aw_hold);
  assign do_write = aw_got && w_got && (bus_st == otc_idle);
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      wmerged[i*8 +: 8] = ws_hold[i] ? w_hold[i*8 +: 8] : 8'h00;
    end
  end

  always_comb
  begin
    next_bus_st = bus_st;
    next_aw_hold = aw_hold;
    next_w_hold = w_hold;
    next_ws_hold = ws_hold;
    next_aw_got = aw_got;
    next_w_got = w_got;
    next_rdata = rdata;
    next_resp = resp;
    // address and data are taken in either order and held until both are in
    if (s_axi_awvalid && !aw_got)
    begin
      next_aw_hold = s_axi_awaddr;
      next_aw_got = 1'b1;
    end
    if (s_axi_wvalid && !w_got)
    begin
      next_w_hold = s_axi_wdata;
      next_ws_hold = s_axi_wstrb;
      next_w_got = 1'b1;
    end
    case (bus_st)
      otc_idle:
      begin
        if (do_write)
        begin
          next_resp = otc_mapped(aw_hold) ? `OTC_RESP_OKAY : `OTC_RESP_SLVERR;
          next_aw_got = 1'b0;
          next_w_got = 1'b0;
          next_bus_st = otc_wresp;
        end
        else if (s_axi_arvalid)
        begin
          next_resp = otc_mapped(s_axi_araddr) ? `OTC_RESP_OKAY : `OTC_RESP_SLVERR;
          case (otc_index(s_axi_araddr))
            `OTC_A_CTRL: next_rdata = ctrl;
            `OTC_A_PRESET: next_rdata = 32'(preset);
            `OTC_A_DIST_IN: next_rdata = 32'(dist_in);
            `OTC_A_THR_IN: next_rdata = 32'(thr_in);
            `OTC_A_DIST: next_rdata = 32'(rep);
            `OTC_A_THR: next_rdata = 32'(thr);
            `OTC_A_STAT: next_rdata = {trig_cnt, 12'h000, host_cmd, emit, applied, pin_level};
            default: next_rdata = 32'h0000_0000;
          endcase
          next_bus_st = otc_rresp;
        end
      end
      otc_wresp: if (s_axi_bready) next_bus_st = otc_idle;
      otc_rresp: if (s_axi_rready) next_bus_st = otc_idle;
      default: next_bus_st = otc_idle;
    endcase
  end

  // ****************************************************************************
  // configuration, offset and emitter logic
  // ****************************************************************************
  always_comb
  begin
    next_ctrl = ctrl;
    next_preset = preset;
    next_dist_in = dist_in;
    next_thr_in = thr_in;
    next_corr = corr;
    next_applied = applied;
    next_trig_cnt = trig_cnt;
    next_host_cmd = 1'b0;
    if (do_write && otc_mapped(aw_hold))
    begin
      case (widx)
        `OTC_A_CTRL:
        begin
          next_ctrl = wmerged;
          // only the listed rates and baud codes are kept; others fall back
          if (wmerged[`OTC_B_RATE] == 3'h7) next_ctrl[`OTC_B_RATE] = 3'h0; // R5
          if (wmerged[`OTC_B_BAUD] == 2'h3) next_ctrl[`OTC_B_BAUD] = 2'h1; // R14
          if (wmerged[`OTC_B_IFMODE] == 2'h3) next_ctrl[`OTC_B_IFMODE] = 2'h0; // R12
        end
        `OTC_A_PRESET: next_preset = DW'(wmerged);
        `OTC_A_DIST_IN: next_dist_in = DW'(wmerged);
        `OTC_A_THR_IN: next_thr_in = DW'(wmerged);
        `OTC_A_CMD:
        begin
          if (wmerged[`OTC_CMD_LOAD]) next_preset = dist_in; // R15
          if (wmerged[`OTC_CMD_CLR]) next_preset = '0; // R15
          if (wmerged[`OTC_CMD_RST]) next_applied = 1'b0; // R16
          next_host_cmd = wmerged[`OTC_CMD_HOST] && (ifmode == otc_if_comm); // R12
        end
        default: ;
      endcase
    end
    // a trigger in the same cycle as a reset command wins: the event is not lost
    if (mf_rise)
    begin
      next_corr = preset - dist_in; // R3
      next_applied = 1'b1; // R3
      next_trig_cnt = trig_cnt + 16'h0001; // R17
    end
  end

  // outputs: distance and thresholds carry the same correction
  always_comb
  begin
    next_rep = applied ? dist_in + corr : dist_in; // R3 R16
    next_thr = applied ? thr_in + corr : thr_in; // R4
    next_emit = ctrl[`OTC_B_LASER] // R7
      && !(ctrl[`OTC_B_PINSER] ? ctrl[`OTC_B_SHUT] : dis_sync[1]) // R8 R9
      && !(pinfn == otc_pin_shutdown && pin_level); // R9
  end

  // ****************************************************************************
  // menu and continuous send pacing
  // ****************************************************************************
  // rate and resolution trade-off lives in the measuring core; this block only selects it R6
  always_comb
  begin
    next_menu_cnt = 32'h0;
    next_cont_cnt = 32'h0;
    next_menu_p = 1'b0;
    next_cont_p = 1'b0;
    if (ifmode == otc_if_menu)
    begin
      next_menu_p = (menu_cnt == 32'(MENU_DIV - 1)); // R11
      next_menu_cnt = next_menu_p ? 32'h0 : menu_cnt + 32'h1;
    end
    if (ifmode == otc_if_cont)
    begin
      next_cont_p = (cont_cnt == 32'(CONT_DIV - 1)); // R13
      next_cont_cnt = next_cont_p ? 32'h0 : cont_cnt + 32'h1;
    end
  end

  // ****************************************************************************
  // registers
  // ****************************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bus_st <= otc_idle;
      ctrl <= `OTC_CTRL_RST;
      preset <= '0;
      dist_in <= '0;
      thr_in <= '0;
      corr <= '0;
      applied <= 1'b0;
      trig_cnt <= 16'h0000;
      mf_sync <= 3'h0;
      dis_sync <= 2'h0;
      host_cmd <= 1'b0;
      aw_hold <= 32'h0;
      w_hold <= 32'h0;
      ws_hold <= 4'h0;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      rdata <= 32'h0;
      resp <= 2'h0;
      menu_cnt <= 32'h0;
      cont_cnt <= 32'h0;
      menu_p <= 1'b0;
      cont_p <= 1'b0;
      emit <= 1'b0;
      rep <= '0;
      thr <= '0;
    end
    else
    begin
      bus_st <= next_bus_st;
      ctrl <= next_ctrl;
      preset <= next_preset;
      dist_in <= next_dist_in;
      thr_in <= next_thr_in;
      corr <= next_corr;
      applied <= next_applied;
      trig_cnt <= next_trig_cnt;
      mf_sync <= next_mf_sync;
      dis_sync <= next_dis_sync;
      host_cmd <= next_host_cmd;
      aw_hold <= next_aw_hold;
      w_hold <= next_w_hold;
      ws_hold <= next_ws_hold;
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      rdata <= next_rdata;
      resp <= next_resp;
      menu_cnt <= next_menu_cnt;
      cont_cnt <= next_cont_cnt;
      menu_p <= next_menu_p;
      cont_p <= next_cont_p;
      emit <= next_emit;
      rep <= next_rep;
      thr <= next_thr;
    end
  end

  // all outputs are decoded from flip-flops only; no input reaches an output without a register
  assign s_axi_awready = !aw_got;
  assign s_axi_wready = !w_got;
  assign s_axi_bvalid = (bus_st == otc_wresp);
  assign s_axi_bresp = resp;
  assign s_axi_arready = (bus_st == otc_idle) && !do_write;
  assign s_axi_rvalid = (bus_st == otc_rresp);
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = resp;
  assign emitter_on = emit;
  assign sample_rate_sel = ctrl[`OTC_B_RATE];
  assign display_selection = ctrl[`OTC_B_DISP];
  assign baud_sel = ctrl[`OTC_B_BAUD];
  assign menu_send = menu_p;
  assign cont_send = cont_p;
  assign host_cmd_enable = host_cmd;
  assign reported_distance = rep;
  assign switch_threshold = thr;

  // ****************************************************************************
  // assertions
  // ****************************************************************************
  AST_ONE_PER_EDGE: assert property (@(posedge aclk) disable iff (!aresetn) // R17
    mf_rise |=> !mf_rise) else $error("two equalizations from one edge");
  AST_PIN_FN: assert property (@(posedge aclk) disable iff (!aresetn) // R1
    (pinfn != otc_pin_offset) |=> $stable(trig_cnt) || $past(pinfn) == otc_pin_offset)
    else $error("trigger taken while pin not in offset function");
  AST_APPLY: assert property (@(posedge aclk) disable iff (!aresetn) // R3
    mf_rise |=> applied ##1 (rep == $past(preset, 2) + $past(dist_in) - $past(dist_in, 2)) || !applied
      || $changed(corr)) else $error("preset not taken as distance");
  AST_THR_SHIFT: assert property (@(posedge aclk) disable iff (!aresetn) // R4
    (rep - dist_in) == (thr - thr_in) || $changed(dist_in) || $changed(thr_in)
      || $changed(applied) || $changed(corr)) else $error("threshold shift differs");
  AST_LASER_OFF: assert property (@(posedge aclk) disable iff (!aresetn) // R7
    !ctrl[`OTC_B_LASER] |=> !emitter_on) else $error("emitter on while disabled");
  AST_DIS_PIN: assert property (@(posedge aclk) disable iff (!aresetn) // R8
    (dis_sync[1] && !ctrl[`OTC_B_PINSER]) |=> !emitter_on) else $error("disable pin ignored");
  AST_RATE: assert property (@(posedge aclk) disable iff (!aresetn) // R5
    sample_rate_sel != 3'h7) else $error("rate code outside set");
  AST_BAUD: assert property (@(posedge aclk) disable iff (!aresetn) // R14
    baud_sel != 2'h3) else $error("baud code outside set");
  AST_MENU: assert property (@(posedge aclk) disable iff (!aresetn) // R11
    menu_send |-> $past(ifmode) == otc_if_menu) else $error("menu sent outside menu mode");
  AST_CONT: assert property (@(posedge aclk) disable iff (!aresetn) // R13
    cont_send |=> !cont_send) else $error("continuous pulse too long");
  COV_TRIG: cover property (@(posedge aclk) mf_rise);
  COV_RST: cover property (@(posedge aclk) applied ##1 !applied);
  COV_WR: cover property (@(posedge aclk) s_axi_bvalid && s_axi_bready);
  COV_RD: cover property (@(posedge aclk) s_axi_rvalid && s_axi_rready);

endmodule // otc_top

//--- verif/otc_trig_model.sv
// model of the outside trigger sensor and the emitter disable line
`timescale 1ns/100ps
module otc_trig_model
(
  input wire logic aclk,
  output logic multifunction_pin,
  output logic disable_pin
);
  // both lines idle low; the pins have no pull, so a known level is driven
  initial
  begin
    multifunction_pin = 1'b0;
    disable_pin = 1'b0;
  end

  // low-to-high edge, held long enough to pass the two-flop synchroniser
  task automatic fire();
    @(posedge aclk);
    multifunction_pin <= 1'b1;
    repeat (4) @(posedge aclk);
    multifunction_pin <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask

  // drive the disable line to the given level
  task automatic shut(input logic v);
    @(posedge aclk);
    disable_pin <= v;
  endtask
endmodule // otc_trig_model

//--- verif/tb_top.sv
// self-checking bench of the offset trigger and configuration block
`timescale 1ns/100ps
`include "otc_consts.svh"
module tb_top;
  import otc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, baud_sel, rs;
  logic multifunction_pin, disable_pin, emitter_on, display_selection;
  logic menu_send, cont_send, host_cmd_enable;
  logic [2:0] sample_rate_sel;
  logic [31:0] reported_distance, switch_threshold, d;
  int n_fail = 0;
  int compares = 0;
  int nh = 0;

  // count host command pulses so a one-cycle output is never missed
  always @(posedge aclk)
  begin
    if (host_cmd_enable === 1'b1) nh <= nh + 1;
  end

  // ************************************************************
  // clock, design and far side
  // ************************************************************
  always #5 aclk = ~aclk;

  otc_top #(.DW(32), .MENU_DIV(4), .CONT_DIV(4)) otc_top_i (.*);
  otc_trig_model otc_trig_model_i (.aclk(aclk), .multifunction_pin(multifunction_pin),
    .disable_pin(disable_pin));

  // ************************************************************
  // bus cycles and comparison
  // ************************************************************
  function automatic logic [31:0] ba(input logic [3:0] i);
    return {26'h0, i, 2'b00};
  endfunction

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  // address and data offered together, bready held until the response
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    rd(ba(`OTC_A_CTRL));
    chk("ctrl", d, `OTC_CTRL_RST | 32'h220);
    chk("baud", {30'h0, baud_sel}, 32'h1);
    chk("emit", {31'h0, emitter_on}, 32'h1);
    $display("test reset done");
  endtask

  // equalization applied, counted once, cancelled, then ignored when unrouted
  task automatic t_offset();
    logic [15:0] c0;
    wr(ba(`OTC_A_DIST_IN), 32'd5000);
    wr(ba(`OTC_A_THR_IN), 32'd7000);
    wr(ba(`OTC_A_PRESET), 32'd3000);
    rd(ba(`OTC_A_STAT));
    c0 = d[31:16];
    otc_trig_model_i.fire();
    rd(ba(`OTC_A_DIST));
    chk("dist", d, 32'd3000);
    chk("dist_port", reported_distance, 32'd3000);
    rd(ba(`OTC_A_THR));
    chk("thr", d, 32'd5000);
    rd(ba(`OTC_A_STAT));
    chk("trig_count", {16'h0, d[31:16]}, {16'h0, c0 + 16'h1});
    wr(ba(`OTC_A_CMD), 32'h4);
    rd(ba(`OTC_A_DIST));
    chk("dist_cancel", d, 32'd5000);
    wr(ba(`OTC_A_CTRL), 32'h220);
    otc_trig_model_i.fire();
    rd(ba(`OTC_A_DIST));
    chk("dist_nofn", d, 32'd5000);
    $display("test offset done");
  endtask

  // preset captured from distance, cleared to zero, zero preset applied
  task automatic t_preset();
    wr(ba(`OTC_A_CTRL), 32'h221);
    wr(ba(`OTC_A_DIST_IN), 32'd4000);
    wr(ba(`OTC_A_CMD), 32'h1);
    rd(ba(`OTC_A_PRESET));
    chk("preset_load", d, 32'd4000);
    wr(ba(`OTC_A_CMD), 32'h2);
    rd(ba(`OTC_A_PRESET));
    chk("preset_clr", d, 32'h0);
    otc_trig_model_i.fire();
    rd(ba(`OTC_A_DIST));
    chk("dist_zero", d, 32'h0);
    rd(ba(`OTC_A_THR));
    chk("thr_zero", d, 32'd3000);
    $display("test preset done");
  endtask

  // every rate, every baud rate and both display choices reach the outputs
  task automatic t_cfg();
    for (int i = 0; i < 7; i++)
    begin
      wr(ba(`OTC_A_CTRL), 32'h221 | (i << 2) | ((i & 1) << 6));
      repeat (2) @(posedge aclk);
      chk("rate", {29'h0, sample_rate_sel}, i);
      chk("disp", {31'h0, display_selection}, i & 1);
    end
    for (int i = 0; i < 3; i++)
    begin
      wr(ba(`OTC_A_CTRL), 32'h021 | (i << 9));
      repeat (2) @(posedge aclk);
      chk("baud_sel", {30'h0, baud_sel}, i);
    end
    // codes outside the listed sets fold back to their defaults
    wr(ba(`OTC_A_CTRL), 32'h7BD);
    rd(ba(`OTC_A_CTRL));
    chk("ctrl_fold", d, 32'h221);
    chk("rate_fold", {29'h0, sample_rate_sel}, 32'h0);
    $display("test config done");
  endtask

  // emitter follows the enable setting and the disable line
  task automatic t_emitter();
    wr(ba(`OTC_A_CTRL), 32'h201);
    repeat (3) @(posedge aclk);
    chk("emit_off", {31'h0, emitter_on}, 32'h0);
    wr(ba(`OTC_A_CTRL), 32'h221);
    otc_trig_model_i.shut(1'b1);
    repeat (4) @(posedge aclk);
    chk("emit_pin", {31'h0, emitter_on}, 32'h0);
    otc_trig_model_i.shut(1'b0);
    repeat (4) @(posedge aclk);
    chk("emit_back", {31'h0, emitter_on}, 32'h1);
    // pin serving the serial link: the line is ignored, the shutdown setting rules
    otc_trig_model_i.shut(1'b1);
    wr(ba(`OTC_A_CTRL), 32'h1221);
    repeat (4) @(posedge aclk);
    chk("emit_ser", {31'h0, emitter_on}, 32'h1);
    wr(ba(`OTC_A_CTRL), 32'h3221);
    repeat (4) @(posedge aclk);
    chk("emit_shut", {31'h0, emitter_on}, 32'h0);
    otc_trig_model_i.shut(1'b0);
    $display("test emitter done");
  endtask

  // menu and continuous modes send unasked; an unmapped place is refused
  task automatic t_modes();
    int nm;
    int nc;
    int h0;
    wr(ba(`OTC_A_CTRL), 32'h221);
    h0 = nh;
    wr(ba(`OTC_A_CMD), 32'h8);
    repeat (3) @(posedge aclk);
    chk("host_cmd", nh - h0, 32'h1);
    for (int m = 1; m < 3; m++)
    begin
      wr(ba(`OTC_A_CTRL), 32'h221 | (m << 7));
      nm = 0;
      nc = 0;
      repeat (12)
      begin
        @(posedge aclk);
        nm += menu_send;
        nc += cont_send;
      end
      chk("menu_send", nm > 1, m == 1);
      chk("cont_send", nc > 1, m == 2);
    end
    h0 = nh;
    wr(ba(`OTC_A_CMD), 32'h8);
    repeat (3) @(posedge aclk);
    chk("host_cmd_cont", nh - h0, 32'h0);
    wr(ba(4'h8), 32'h1);
    chk("wresp", {30'h0, rs}, `OTC_RESP_SLVERR);
    $display("test modes done");
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // watchdog: all scenarios need well under a tenth of this span
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    conclude();
  end

  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_offset();
    t_preset();
    t_cfg();
    t_emitter();
    t_modes();
    conclude();
  end
endmodule // tb_top
